//--- logic/dss_pkg.sv
// Constants and types shared by the start-up sequencer files.
// Assumes a single 25 MHz crystal clock domain and a synchronous reset.
// Overview of operation
// - Capture divider pins at reset pin release.
// - Subsystem clocks gated until initialization ends.
// - Init lasts 2^15 divided crystal periods.
// - Pins 000/001/010/011/100 give 1/2/4/6/8.
// - Core rate 0x001C at 0xE220 stops start.
// - Other core rate value re-enables start while the core module clock is enabled.
// - Five module clocks switchable off individually.
`default_nettype none
package dss_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int SEL_W = 3;
  localparam int DIV_W = 4;
  localparam int NUM_MODULES = 5;
  localparam int INIT_EXP = 15;
  localparam int INIT_TICKS = 2 ** INIT_EXP;

  localparam logic [ADDR_W-1:0] CORE_RATE_SELECT_ADDR = 16'he220;
  localparam logic [DATA_W-1:0] CORE_RATE_STOP = 16'h001c;
  localparam logic [DATA_W-1:0] CORE_RATE_RESET = 16'h0000;

  // Divider select pin patterns and their divide ratios.
  localparam logic [SEL_W-1:0] SEL_DIV1 = 3'h0;
  localparam logic [SEL_W-1:0] SEL_DIV2 = 3'h1;
  localparam logic [SEL_W-1:0] SEL_DIV4 = 3'h2;
  localparam logic [SEL_W-1:0] SEL_DIV6 = 3'h3;
  localparam logic [SEL_W-1:0] SEL_DIV8 = 3'h4;
  localparam logic [DIV_W-1:0] DIV_1 = 4'h1;
  localparam logic [DIV_W-1:0] DIV_2 = 4'h2;
  localparam logic [DIV_W-1:0] DIV_4 = 4'h4;
  localparam logic [DIV_W-1:0] DIV_6 = 4'h6;
  localparam logic [DIV_W-1:0] DIV_8 = 4'h8;

  // Module clock enable bit positions.
  localparam int CLK_SRC = 0;
  localparam int CLK_RX = 1;
  localparam int CLK_TX = 2;
  localparam int CLK_AUX = 3;
  localparam int CLK_CORE = 4;

  typedef struct packed {
    logic write;
    logic read;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } dss_ctrl_req_t;

  typedef enum logic [2:0] {
    ST_HELD = 3'b001,
    ST_INIT = 3'b010,
    ST_RUN = 3'b100
  } dss_state_t;

  function automatic logic [DIV_W-1:0] dss_decode_div(
    input logic [SEL_W-1:0] sel
  );
    case (sel)
      SEL_DIV1: dss_decode_div = DIV_1;
      SEL_DIV2: dss_decode_div = DIV_2;
      SEL_DIV4: dss_decode_div = DIV_4;
      SEL_DIV6: dss_decode_div = DIV_6;
      SEL_DIV8: dss_decode_div = DIV_8;
      default: dss_decode_div = DIV_1;
    endcase
  endfunction

endpackage
`default_nettype wire

//--- logic/dss_tick_div.sv
// One-cycle enable pulse every DIV_W-coded number of clock cycles.
// Assumes the divide value is stable while run is high.
`timescale 1ns/100ps
`default_nettype none
module dss_tick_div (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic run,
  input wire logic [dss_pkg::DIV_W-1:0] divide,
  output logic tick
);

  logic [dss_pkg::DIV_W-1:0] count;
  wire logic atEnd = (count == divide - 4'h1);

  always_ff @(posedge ref_clk) begin
    if (srst || !run) begin
      count <= '0;
      tick <= 1'b0;
    end else begin
      count <= atEnd ? '0 : count + 4'h1;
      tick <= atEnd;
    end
  end

endmodule // dss_tick_div
`default_nettype wire

//--- logic/dss_startup_sequencer.sv
// Start-up sequencer: reset-pin release, divider capture, init timing,
// subsystem clock gating and the core rate select register.
// Assumes ref_clk is the crystal clock and the control port has already
// been turned into single-cycle read and write requests on ref_clk.
`timescale 1ns/100ps
`default_nettype none
module dss_startup_sequencer #(
  parameter int INIT_TICKS = dss_pkg::INIT_TICKS
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic resetPin_n,
  input wire logic divider_select_bit0,
  input wire logic divider_select_bit1,
  input wire logic divider_select_bit2,
  input wire dss_pkg::dss_ctrl_req_t ctrlReq,
  input wire logic [dss_pkg::NUM_MODULES-1:0] moduleClkEnable,
  output logic [dss_pkg::DATA_W-1:0] ctrlRdData,
  output logic ctrlRdValid,
  output logic initDone,
  output logic [dss_pkg::DIV_W-1:0] pllDivider,
  output logic [dss_pkg::NUM_MODULES-1:0] subsysClkEn,
  output logic coreStartEnable
);

  localparam int CNT_W = $clog2(INIT_TICKS + 1);

  // Pins are asynchronous to ref_clk; two flops before any use.
  logic [3:0] pinMeta;
  logic [3:0] pinSync;
  logic resetPinLast;
  always_ff @(posedge ref_clk) begin
    pinMeta <= {resetPin_n, divider_select_bit2, divider_select_bit1,
                divider_select_bit0};
    pinSync <= pinMeta;
  end

  wire logic resetPinHigh = pinSync[3];
  wire logic [dss_pkg::SEL_W-1:0] selSync = pinSync[2:0];
  wire logic releaseEdge = resetPinHigh && !resetPinLast;

  dss_pkg::dss_state_t state;
  dss_pkg::dss_state_t next_state;
  logic [CNT_W-1:0] tickCount;
  logic [dss_pkg::DATA_W-1:0] coreRate;
  logic divTick;

  wire logic counting = (state == dss_pkg::ST_INIT);
  wire logic lastTick = divTick &&
    (tickCount == CNT_W'(INIT_TICKS - 1));

  always_comb begin
    next_state = state;
    case (state)
      dss_pkg::ST_HELD: begin
        if (releaseEdge) begin
          next_state = dss_pkg::ST_INIT;
        end
      end
      dss_pkg::ST_INIT: begin
        if (!resetPinHigh) begin
          next_state = dss_pkg::ST_HELD;
        end else if (lastTick) begin
          next_state = dss_pkg::ST_RUN;
        end
      end
      dss_pkg::ST_RUN: begin
        if (!resetPinHigh) begin
          next_state = dss_pkg::ST_HELD;
        end
      end
      default: next_state = dss_pkg::ST_HELD;
    endcase
  end

  // The divider counts crystal cycles; its pulse paces the init count.
  dss_tick_div u_tick_div (
    .ref_clk(ref_clk),
    .srst(srst),
    .run(counting),
    .divide(pllDivider),
    .tick(divTick)
  );

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      resetPinLast <= 1'b0;
      state <= dss_pkg::ST_HELD;
      tickCount <= '0;
      pllDivider <= dss_pkg::DIV_1;
    end else begin
      resetPinLast <= resetPinHigh;
      state <= next_state;
      if (releaseEdge) begin
        pllDivider <= dss_pkg::dss_decode_div(selSync);
      end
      if (!counting) begin
        tickCount <= '0;
      end else if (divTick) begin
        tickCount <= tickCount + CNT_W'(1);
      end
    end
  end

  // Writes before init completes are dropped, so the register cannot be
  // disturbed while its reset value is still being applied.
  wire logic running = (state == dss_pkg::ST_RUN);
  wire logic hitRate = (ctrlReq.addr == dss_pkg::CORE_RATE_SELECT_ADDR);
  wire logic rateWrite = running && ctrlReq.write && hitRate;
  wire logic rateRead = running && ctrlReq.read;
  wire logic [dss_pkg::DATA_W-1:0] readMux = hitRate ? coreRate : '0;
  wire logic startOk = (coreRate != dss_pkg::CORE_RATE_STOP);
  wire logic [dss_pkg::NUM_MODULES-1:0] gatedEn =
    running ? moduleClkEnable : '0;

  always_ff @(posedge ref_clk) begin
    if (srst || !running) begin
      coreRate <= dss_pkg::CORE_RATE_RESET;
      ctrlRdData <= '0;
      ctrlRdValid <= 1'b0;
      initDone <= 1'b0;
      subsysClkEn <= '0;
      coreStartEnable <= 1'b0;
    end else begin
      if (rateWrite) begin
        coreRate <= ctrlReq.data;
      end
      ctrlRdValid <= rateRead;
      ctrlRdData <= rateRead ? readMux : '0;
      initDone <= 1'b1;
      subsysClkEn <= gatedEn;
      coreStartEnable <= startOk && gatedEn[dss_pkg::CLK_CORE];
    end
  end

endmodule // dss_startup_sequencer
`default_nettype wire

//--- tb/dss_startup_sequencer_properties.sv
// Timing checks on the start-up sequencer ports.
// Assumes one ref_clk domain and a synchronous active-high srst.
`timescale 1ns/100ps
`default_nettype none
module dss_checker #(parameter int INIT_TICKS = 8) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic resetPin_n,
  input wire dss_pkg::dss_ctrl_req_t ctrlReq,
  input wire logic [4:0] moduleClkEnable,
  input wire logic ctrlRdValid,
  input wire logic initDone,
  input wire logic [3:0] pllDivider,
  input wire logic [4:0] subsysClkEn,
  input wire logic coreStartEnable
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  logic [9:0] cnt;
  // Counts from the raw pin release so that sync latency stays bounded.
  always_ff @(posedge ref_clk) begin
    cnt <= (srst || !resetPin_n) ? 10'h0 : cnt + 10'h1;
  end
  sequence s_rate;
    ctrlReq.write && initDone && ctrlReq.addr == 16'he220;
  endsequence
  AST_DIV_HOLD: assert property (initDone && $past(initDone) |->
    $stable(pllDivider)) else $error("divider changed while running");
  AST_GATED: assert property (!initDone && !$past(initDone) |->
    subsysClkEn == 5'h0) else $error("clock leaked during init");
  AST_INIT_LEN: assert property ($rose(initDone) |->
    int'(cnt) >= INIT_TICKS * int'(pllDivider) &&
    int'(cnt) <= INIT_TICKS * int'(pllDivider) + 8)
    else $error("init length wrong");
  AST_DIV_LEGAL: assert property (initDone |->
    pllDivider inside {4'h1, 4'h2, 4'h4, 4'h6, 4'h8})
    else $error("illegal divider");
  AST_STOP: assert property (s_rate ##0 ctrlReq.data == 16'h001c
    |-> ##2 !coreStartEnable) else $error("start pulse not stopped");
  AST_START: assert property (s_rate ##0 ctrlReq.data != 16'h001c
    ##0 moduleClkEnable[4] ##1 moduleClkEnable[4] |=> coreStartEnable)
    else $error("start pulse not enabled");
  AST_FOLLOW: assert property (initDone && $past(initDone) |->
    subsysClkEn == $past(moduleClkEnable)) else $error("gating wrong");
  // Requests are taken from the first run cycle, and initDone shows that
  // run state one cycle later, so it lines up with the read answer.
  AST_READ: assert property (ctrlReq.read |=>
    ctrlRdValid == initDone) else $error("read answer wrong");
endmodule // dss_checker
bind dss_startup_sequencer dss_checker #(.INIT_TICKS(INIT_TICKS))
  dss_checker_i (.ref_clk, .srst, .resetPin_n, .ctrlReq, .moduleClkEnable,
  .ctrlRdValid, .initDone, .pllDivider, .subsysClkEn, .coreStartEnable);
`default_nettype wire

//--- tb/dss_host_model.sv
// Host on the control port: single requests and the boot sequence.
// Assumes the bench calls boot only after initDone is high.
`timescale 1ns/100ps
`default_nettype none
module dss_host_model (
  input wire logic ref_clk,
  output dss_pkg::dss_ctrl_req_t ctrlReq,
  output logic [4:0] moduleClkEnable
);
  initial ctrlReq = '0;
  initial moduleClkEnable = 5'h0;
  // Idle address and data are inverted so stale values never match.
  task automatic xfer(input logic w, r, input logic [15:0] a, d);
    @(posedge ref_clk);
    ctrlReq <= {w, r, a, d};
    @(posedge ref_clk);
    ctrlReq <= {2'b00, ~a, ~d};
  endtask
  task automatic boot(input logic [15:0] rate, input logic [4:0] en);
    moduleClkEnable <= en;
    xfer(1'b1, 1'b0, 16'he220, 16'h001c);
    xfer(1'b1, 1'b0, 16'he000, 16'h0003);
    xfer(1'b1, 1'b0, 16'h0fff, 16'h1234);
    xfer(1'b1, 1'b0, 16'he221, 16'h0001);
    xfer(1'b1, 1'b0, 16'he220, rate);
  endtask
endmodule // dss_host_model
`default_nettype wire

//--- tb/dss_startup_sequencer_tb_top.sv
// Bench for the start-up sequencer: every divider code, boot, readback.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/100ps
`default_nettype none
module dss_startup_sequencer_tb_top;
  logic ref_clk = 1'b0, srst = 1'b1, resetPin_n = 1'b0;
  logic [2:0] sel = 3'h0;
  dss_pkg::dss_ctrl_req_t ctrlReq;
  logic [4:0] moduleClkEnable, subsysClkEn, en;
  logic [15:0] ctrlRdData, rate;
  logic ctrlRdValid, initDone, coreStartEnable;
  logic [3:0] pllDivider;
  int n_errors = 0, samples_checked = 0, cyc = 0, k;
  always #20 ref_clk = ~ref_clk;
  dss_startup_sequencer #(.INIT_TICKS(8)) dss_startup_sequencer_i (
    .ref_clk, .srst, .resetPin_n, .divider_select_bit0(sel[0]),
    .divider_select_bit1(sel[1]), .divider_select_bit2(sel[2]), .ctrlReq,
    .moduleClkEnable, .ctrlRdData, .ctrlRdValid, .initDone, .pllDivider,
    .subsysClkEn, .coreStartEnable);
  dss_host_model dss_host_model_i (.ref_clk, .ctrlReq, .moduleClkEnable);
  function automatic logic [15:0] exp_div(input logic [2:0] s);
    case (s)
      3'h1: return 16'h2;
      3'h2: return 16'h4;
      3'h3: return 16'h6;
      3'h4: return 16'h8;
      default: return 16'h1;
    endcase
  endfunction
  task automatic check(input string what, input logic [15:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude;
    $display("checked %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      conclude();
    end
  end
  task automatic rd(input logic [15:0] a);
    dss_host_model_i.xfer(1'b0, 1'b1, a, 16'h0);
    @(negedge ref_clk);
  endtask
  initial begin
    k = $urandom(32'h411cbead);
    repeat (10) @(posedge ref_clk);
    srst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      @(posedge ref_clk);
      resetPin_n <= 1'b0;
      sel <= i[2:0];
      repeat (4) @(posedge ref_clk);
      resetPin_n <= 1'b1;
      rd(16'he220);
      check("early read", ctrlRdValid, 1'b0);
      check("gated", 16'(subsysClkEn), 16'h0);
      repeat (6) @(posedge ref_clk);
      sel <= ~sel;
      k = 0;
      while (initDone !== 1'b1 && k < 200) begin
        @(posedge ref_clk);
        k++;
      end
      check("init done", initDone, 1'b1);
      check("divider", 16'(pllDivider), exp_div(i[2:0]));
      rate = (i == 7) ? 16'h001c : 16'($urandom);
      en = 5'($urandom);
      dss_host_model_i.boot(rate, en);
      repeat (2) @(negedge ref_clk);
      check("start", coreStartEnable, rate != 16'h001c && en[4]);
      check("clocks", 16'(subsysClkEn), 16'(en));
      rd(16'he220);
      check("rate", ctrlRdData, rate);
      rd(16'he221);
      check("other", ctrlRdData, 16'h0);
      dss_host_model_i.xfer(1'b1, 1'b0, 16'he220, 16'h001c);
      repeat (2) @(negedge ref_clk);
      check("stop", coreStartEnable, 1'b0);
      $display("test sel %0d done", i);
    end
    conclude();
  end
endmodule // dss_startup_sequencer_tb_top
`default_nettype wire
